// ==== design/eepc_ctrl.sv ====
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "eepc_params.svh"

// Function
// - nv config arm bit cleared once secures top 16 bytes of block one.
// - secured 16 bytes refuse program and erase yet read normally.
// - once secured, the nv config register refuses program and erase.
// - once secured, block and bulk erase are refused on every array byte.
// - once secured, byte program and erase still work on open bytes.
// - security never reverts and nv config stays frozen.
// - four 128-byte blocks; a protect bit blocks program and erase.
// - protect bits reload from nv config at reset and on its read.
// - nv divider lock bit at zero loads working lock zero each reset.
// - divider lock refuses nv divider changes and working divider writes.
// - erased cells read one; array ships as all ones.
// - program only clears bits, one to eight bits of one byte.
// - erase sets bits, from one byte up to the whole array.
// - timed termination ends the cycle and clears program enable early.
// - with latch set only valid writes capture; control waits for one.
// - later writes replace capture; latched reads return data, take address.
// - enable ignored without latch or capture; enable starts sequence.
// - clearing enable and latch together clears only enable.
// - latch cannot clear while enable is set.
// - mode bits pick program or erase kind; protect forces no operation.
// - timing ticks every 35 us from the divided reference clock.

module eepc_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdata,
    output logic pumpOn,
    output logic secured
);

    eepc_pkg::eepc_state_t s_reg;
    eepc_pkg::eepc_state_t s_next;

    logic memWe;
    logic [9:0] memWaddr;
    logic [7:0] memWdata;
    logic [9:0] memRaddr;
    logic [7:0] memRdata;
    logic tick;
    logic [15:0] divisor;
    logic divLocked;
    logic [7:0] need;
    logic [7:0] ctrlNew;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic isArray(input logic [15:0] a);
        return a >= `EEPC_ARRAY_BASE && a <= `EEPC_ARRAY_LAST;
    endfunction

    function automatic logic isNv(input logic [15:0] a);
        return a >= `EEPC_NVCFG_ADDR && a <= `EEPC_NVDIVL_ADDR;
    endfunction

    // array bytes and the three nv bytes share one latch path
    function automatic logic isCell(input logic [15:0] a);
        return isArray(a) || isNv(a);
    endfunction

    function automatic logic [9:0] idxOf(input logic [15:0] a);
        logic [15:0] d;
        d = isArray(a) ? a - `EEPC_ARRAY_BASE
                       : a - `EEPC_NVCFG_ADDR + 16'h0200;
        return d[9:0];
    endfunction

    // whether one cell may change under the given operation
    function automatic logic cellOk(input logic [9:0] idx,
                                    input eepc_pkg::eepc_mode_t mode,
                                    input logic [3:0] bp,
                                    input logic sec,
                                    input logic lock);
        logic ok;
        ok = 1'b1;
        if (idx == `EEPC_IDX_NVCFG) begin
            ok = !sec;
        end else if (idx >= `EEPC_IDX_NVDIVH) begin
            ok = !lock;
        end else begin
            if (bp[idx[8:7]]) begin
                ok = 1'b0;
            end
            if (sec && idx >= `EEPC_SECURE_LO && idx <= `EEPC_SECURE_HI) begin
                ok = 1'b0;
            end
            if (sec && mode[1]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [7:0] ticksFor(input eepc_pkg::eepc_mode_t m);
        unique case (m)
            eepc_pkg::EEPC_BYTE_PGM: return `EEPC_PGM_TICKS;
            eepc_pkg::EEPC_BYTE_ERASE: return `EEPC_BYTE_ERASE_TICKS;
            eepc_pkg::EEPC_BLOCK_ERASE: return `EEPC_BLOCK_ERASE_TICKS;
            eepc_pkg::EEPC_BULK_ERASE: return `EEPC_BULK_ERASE_TICKS;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    eepc_mem u_mem (
        .clk(clk),
        .we(memWe),
        .waddr(memWaddr),
        .wdata(memWdata),
        .raddr(memRaddr),
        .rdata(memRdata)
    );

    assign divLocked = !s_reg.divHigh[`EEPC_DIVH_LOCK];
    // the lock bit sits in the divider high byte and is not part of the count
    assign divisor = {1'b0, s_reg.divHigh[6:0], s_reg.divLow};
    assign need = ticksFor(s_reg.opMode);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        memWe = 1'b0;
        memWaddr = s_reg.walkIdx;
        memWdata = `EEPC_ERASED;
        memRaddr = idxOf(addr);
        s_next.cfgReload = 1'b0;
        s_next.rdSel = eepc_pkg::EEPC_RD_REG;
        ctrlNew = s_reg.ctrl;

        // 35 us timebase from the divided reference clock
        tick = 1'b0;
        // a zero divisor stops the timebase, so no cycle can complete
        if (divisor == 16'h0000) begin
            s_next.tickCnt = 16'h0000;
        end else if (s_reg.tickCnt >= divisor - 16'h0001) begin
            tick = 1'b1;
            s_next.tickCnt = 16'h0000;
        end else begin
            s_next.tickCnt = s_reg.tickCnt + 16'h0001;
        end

        // ------------------------------------------------------------
        // reads
        // ------------------------------------------------------------
        if (rdStb) begin
            s_next.rdHold = 8'h00;
            if (isCell(addr) && s_reg.ctrl[`EEPC_CTRL_LAT]) begin
                s_next.rdHold = s_reg.latData;
                s_next.latIdx = idxOf(addr);
                if (s_reg.ctrl[`EEPC_CTRL_PGM]) begin
                    // a read under high voltage spoils the cycle
                    s_next.readFail = 1'b1;
                end
            end else if (isCell(addr)) begin
                s_next.rdSel = eepc_pkg::EEPC_RD_MEM;
                if (addr == `EEPC_NVCFG_ADDR) begin
                    s_next.cfgReload = 1'b1;
                end
            end else if (addr == `EEPC_CTRL_ADDR) begin
                s_next.rdHold = s_reg.ctrl;
            end else if (addr == `EEPC_ACR_ADDR) begin
                s_next.rdHold = {3'h0, !s_reg.secure, s_reg.blockProtect};
            end else if (addr == `EEPC_DIVH_ADDR) begin
                s_next.rdHold = s_reg.divHigh;
            end else if (addr == `EEPC_DIVL_ADDR) begin
                s_next.rdHold = s_reg.divLow;
            end
        end
        // the new protect bits act one cycle after the nv config read
        if (s_reg.cfgReload) begin
            s_next.blockProtect = memRdata[3:0];
        end

        // ------------------------------------------------------------
        // writes
        // ------------------------------------------------------------
        if (wrStb) begin
            // direct writes to cells are dropped; only the latch stores
            if (isCell(addr) && s_reg.ctrl[`EEPC_CTRL_LAT]
                && !s_reg.ctrl[`EEPC_CTRL_PGM]) begin
                s_next.latIdx = idxOf(addr);
                s_next.latData = wdata;
                s_next.captured = 1'b1;
            end else if (addr == `EEPC_CTRL_ADDR
                && (!s_reg.ctrl[`EEPC_CTRL_LAT] || s_reg.captured)) begin
                ctrlNew = wdata;
                // latch holds while enable is set
                ctrlNew[`EEPC_CTRL_LAT] = wdata[`EEPC_CTRL_LAT]
                    || s_reg.ctrl[`EEPC_CTRL_PGM];
                ctrlNew[`EEPC_CTRL_PGM] = wdata[`EEPC_CTRL_PGM]
                    && (s_reg.ctrl[`EEPC_CTRL_PGM]
                        || (s_reg.ctrl[`EEPC_CTRL_LAT] && s_reg.captured
                            && s_reg.fsm == eepc_pkg::EEPC_IDLE));
                s_next.ctrl = ctrlNew;
                if (!ctrlNew[`EEPC_CTRL_LAT]) begin
                    s_next.captured = 1'b0;
                end
            end else if (addr == `EEPC_DIVH_ADDR && !divLocked) begin
                s_next.divHigh = wdata;
            end else if (addr == `EEPC_DIVL_ADDR && !divLocked) begin
                s_next.divLow = wdata;
            end
        end

        // ------------------------------------------------------------
        // sequencer
        // ------------------------------------------------------------
        unique case (s_reg.fsm)
            eepc_pkg::EEPC_BOOT0: begin
                memRaddr = `EEPC_IDX_NVCFG;
                s_next.fsm = eepc_pkg::EEPC_BOOT1;
            end
            eepc_pkg::EEPC_BOOT1: begin
                memRaddr = `EEPC_IDX_NVDIVH;
                s_next.blockProtect = memRdata[3:0];
                s_next.secure = !memRdata[`EEPC_ACR_ARM];
                s_next.fsm = eepc_pkg::EEPC_BOOT2;
            end
            eepc_pkg::EEPC_BOOT2: begin
                memRaddr = `EEPC_IDX_NVDIVL;
                s_next.divHigh = memRdata;
                s_next.fsm = eepc_pkg::EEPC_BOOT3;
            end
            eepc_pkg::EEPC_BOOT3: begin
                s_next.divLow = memRdata;
                s_next.fsm = eepc_pkg::EEPC_IDLE;
            end
            eepc_pkg::EEPC_IDLE: begin
                if (s_next.ctrl[`EEPC_CTRL_PGM]) begin
                    s_next.fsm = eepc_pkg::EEPC_RUN;
                    s_next.ticks = 8'h00;
                    s_next.readFail = 1'b0;
                    s_next.opMode = eepc_pkg::eepc_mode_t'(
                        s_next.ctrl[`EEPC_CTRL_MODE_HI:`EEPC_CTRL_MODE_LO]);
                    s_next.opOk = cellOk(s_next.latIdx, s_next.opMode,
                        s_reg.blockProtect, s_reg.secure, divLocked);
                end
            end
            eepc_pkg::EEPC_RUN: begin
                if (tick && s_reg.ticks != 8'hFF) begin
                    s_next.ticks = s_reg.ticks + 8'h01;
                end
                if (s_reg.ctrl[`EEPC_CTRL_AUTO]
                    && s_reg.ticks >= need - `EEPC_AUTO_EARLY) begin
                    // internal timer ends the cycle a tick early
                    s_next.ctrl[`EEPC_CTRL_PGM] = 1'b0;
                end
                if (!s_next.ctrl[`EEPC_CTRL_PGM]) begin
                    s_next.fsm = eepc_pkg::EEPC_IDLE;
                    // a cycle cut short leaves the cells untouched
                    if (s_reg.opOk && !s_next.readFail
                        && (s_reg.ticks >= need - `EEPC_AUTO_EARLY)) begin
                        s_next.fsm = eepc_pkg::EEPC_APPLY;
                        s_next.phase = 1'b0;
                        s_next.walkIdx = s_reg.latIdx;
                        s_next.walkEnd = s_reg.latIdx;
                        if (s_reg.latIdx < `EEPC_ARRAY_SIZE) begin
                            if (s_reg.opMode == eepc_pkg::EEPC_BLOCK_ERASE) begin
                                s_next.walkIdx = s_reg.latIdx & `EEPC_BLOCK_MASK;
                                s_next.walkEnd = s_next.walkIdx
                                    | `EEPC_BLOCK_TOP;
                            end else if (s_reg.opMode
                                         == eepc_pkg::EEPC_BULK_ERASE) begin
                                s_next.walkIdx = 10'h000;
                                s_next.walkEnd = `EEPC_BULK_LAST;
                            end
                        end
                    end
                end
            end
            eepc_pkg::EEPC_APPLY: begin
                if (s_reg.opMode == eepc_pkg::EEPC_BYTE_PGM) begin
                    memRaddr = s_reg.latIdx;
                    s_next.phase = 1'b1;
                    if (s_reg.phase) begin
                        memWe = 1'b1;
                        memWaddr = s_reg.latIdx;
                        // programming can only pull bits to zero
                        memWdata = memRdata & s_reg.latData;
                        if (s_reg.latIdx == `EEPC_IDX_NVCFG
                            && !memWdata[`EEPC_ACR_ARM]) begin
                            s_next.secure = 1'b1;
                        end
                        s_next.fsm = eepc_pkg::EEPC_IDLE;
                    end
                end else begin
                    // erase walks one cell per clock, skipping guarded cells
                    memWe = cellOk(s_reg.walkIdx, s_reg.opMode,
                        s_reg.blockProtect, s_reg.secure, divLocked);
                    memWdata = `EEPC_ERASED;
                    s_next.walkIdx = s_reg.walkIdx + 10'h001;
                    if (s_reg.walkIdx == s_reg.walkEnd) begin
                        s_next.fsm = eepc_pkg::EEPC_IDLE;
                    end
                end
            end
            default: begin
                // a corrupted state code reloads the nv settings
                s_next.fsm = eepc_pkg::EEPC_BOOT0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.fsm <= eepc_pkg::EEPC_BOOT0;
            s_reg.ctrl <= `EEPC_CTRL_RESET;
            s_reg.divHigh <= `EEPC_ERASED;
            s_reg.divLow <= `EEPC_ERASED;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata = (s_reg.rdSel == eepc_pkg::EEPC_RD_MEM) ? memRdata
                                                          : s_reg.rdHold;
    // a refused target never raises the pump
    assign pumpOn = (s_reg.fsm == eepc_pkg::EEPC_RUN) && s_reg.opOk;
    assign secured = s_reg.secure;

endmodule

// ==== design/eepc_params.svh ====
`ifndef EEPC_PARAMS_SVH
`define EEPC_PARAMS_SVH

// ----------------------------------------------------------------
// address map of the register port
// ----------------------------------------------------------------
`define EEPC_ARRAY_BASE 16'h0800
`define EEPC_ARRAY_LAST 16'h09FF
`define EEPC_NVCFG_ADDR 16'h0A00
`define EEPC_NVDIVH_ADDR 16'h0A01
`define EEPC_NVDIVL_ADDR 16'h0A02
`define EEPC_CTRL_ADDR 16'h0A08
`define EEPC_ACR_ADDR 16'h0A09
`define EEPC_DIVH_ADDR 16'h0A0A
`define EEPC_DIVL_ADDR 16'h0A0B

// ----------------------------------------------------------------
// cell indexes inside the storage module
// ----------------------------------------------------------------
`define EEPC_MEM_DEPTH 515
`define EEPC_ARRAY_SIZE 10'h200
`define EEPC_IDX_NVCFG 10'h200
`define EEPC_IDX_NVDIVH 10'h201
`define EEPC_IDX_NVDIVL 10'h202
`define EEPC_SECURE_LO 10'h0F0
`define EEPC_SECURE_HI 10'h0FF
`define EEPC_BLOCK_MASK 10'h380
`define EEPC_BLOCK_TOP 10'h07F
`define EEPC_BULK_LAST 10'h1FF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EEPC_CTRL_PGM 0
`define EEPC_CTRL_AUTO 1
`define EEPC_CTRL_LAT 2
`define EEPC_CTRL_MODE_LO 3
`define EEPC_CTRL_MODE_HI 4
`define EEPC_CTRL_OFF 5
`define EEPC_ACR_ARM 4
`define EEPC_DIVH_LOCK 7

// ----------------------------------------------------------------
// reset values and timing in 35 us ticks
// ----------------------------------------------------------------
`define EEPC_CTRL_RESET 8'h00
`define EEPC_ERASED 8'hFF
`define EEPC_TICK_NS 35000
`define EEPC_CLK_NS 5
`define EEPC_PGM_TICKS 8'h0A
`define EEPC_BYTE_ERASE_TICKS 8'h0A
`define EEPC_BLOCK_ERASE_TICKS 8'h0A
`define EEPC_BULK_ERASE_TICKS 8'h0A
`define EEPC_AUTO_EARLY 8'h01

`endif

// ==== design/eepc_pkg.sv ====
package eepc_pkg;

    typedef enum logic [6:0] {
        EEPC_BOOT0 = 7'h01,
        EEPC_BOOT1 = 7'h02,
        EEPC_BOOT2 = 7'h04,
        EEPC_BOOT3 = 7'h08,
        EEPC_IDLE = 7'h10,
        EEPC_RUN = 7'h20,
        EEPC_APPLY = 7'h40
    } eepc_fsm_t;

    typedef enum logic [1:0] {
        EEPC_BYTE_PGM = 2'h0,
        EEPC_BYTE_ERASE = 2'h1,
        EEPC_BLOCK_ERASE = 2'h2,
        EEPC_BULK_ERASE = 2'h3
    } eepc_mode_t;

    typedef enum logic [1:0] {
        EEPC_RD_REG = 2'h0,
        EEPC_RD_MEM = 2'h1
    } eepc_rdsel_t;

    typedef struct packed {
        eepc_fsm_t fsm;
        logic [7:0] ctrl;
        logic [3:0] blockProtect;
        logic secure;
        logic [7:0] divHigh;
        logic [7:0] divLow;
        logic captured;
        logic [9:0] latIdx;
        logic [7:0] latData;
        logic [15:0] tickCnt;
        logic [7:0] ticks;
        logic readFail;
        logic opOk;
        eepc_mode_t opMode;
        logic phase;
        logic [9:0] walkIdx;
        logic [9:0] walkEnd;
        eepc_rdsel_t rdSel;
        logic [7:0] rdHold;
        logic cfgReload;
    } eepc_state_t;

endpackage

// ==== design/eepc_mem.sv ====
`timescale 1ns/1ps
`include "eepc_params.svh"

module eepc_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [9:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [9:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] cells [0:`EEPC_MEM_DEPTH-1];

    // ----------------------------------------------------------------
    // shipped state: every cell erased
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < `EEPC_MEM_DEPTH; i++) begin
            cells[i] = `EEPC_ERASED;
        end
    end

    // no reset: the contents are nonvolatile
    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end

endmodule

// ==== verification/eepc_cpu_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// cpu bus master: idle lines show inverses
// ------------------------------------------
module eepc_cpu (
    input wire logic clk,
    output logic [15:0] addr,
    output logic [7:0] wdata,
    output logic wrStb,
    output logic rdStb,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 16'hA5A5;
        wdata = 8'h5A;
        wrStb = 1'b0;
        rdStb = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// ==== verification/eepc_properties.sv ====
`timescale 1ns/1ps
`include "eepc_params.svh"
// ------------------------------------------
// port checker
// ------------------------------------------
module eepc_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdata,
    input wire logic pumpOn,
    input wire logic secured
);
    logic [15:0] lastAcc;
    logic [7:0] ctrlW;
    logic [2:0] bootCnt;
    logic enW;
    logic ctlW;
    assign ctlW = wrStb && addr == `EEPC_CTRL_ADDR;
    assign enW = ctlW && wdata[0];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lastAcc <= 16'h0000;
            ctrlW <= 8'h00;
            bootCnt <= 3'h0;
        end else begin
            if (bootCnt != 3'h7) bootCnt <= bootCnt + 3'h1;
            if ((wrStb || rdStb) && addr >= `EEPC_ARRAY_BASE
                && addr <= `EEPC_NVDIVL_ADDR) lastAcc <= addr;
            if (ctlW) ctrlW <= wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_boot_quiet: assert property (bootCnt < 3'h4 |-> !pumpOn)
        else $error("pump on during boot");
    chk_pump_cause: assert property ($rose(pumpOn) |->
        $past(enW) || $past(enW, 2)) else $error("pump without enable");
    chk_pump_off: assert property (ctlW && !wdata[0] |-> ##[1:2] !pumpOn)
        else $error("pump stays after clear");
    chk_auto_bound: assert property ($rose(pumpOn) && ctrlW[1] |->
        ##[1:1000] !pumpOn) else $error("auto never ends");
    chk_latch_hold: assert property (
        rdStb && addr == `EEPC_CTRL_ADDR && pumpOn |=> rdata[2])
        else $error("latch clear while pumping");
    chk_sec_sticky: assert property (secured |=> secured)
        else $error("security dropped");
    chk_sec_region: assert property (pumpOn && secured |->
        !(lastAcc inside {[16'h08F0:16'h08FF]})) else $error("secured hit");
    chk_sec_nvcfg: assert property (pumpOn && secured |->
        lastAcc != `EEPC_NVCFG_ADDR) else $error("config changed");
    chk_sec_bulk: assert property (pumpOn && secured |-> !ctrlW[4])
        else $error("block or bulk erase when secured");
    cover property ($rose(pumpOn) && ctrlW[1]);
    cover property ($rose(secured));
    cover property (pumpOn && ctrlW[4:3] == 2'h3);
endmodule
bind eepc_ctrl eepc_properties chk_u (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
    .pumpOn(pumpOn), .secured(secured));

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "eepc_params.svh"
module tb_top;
    logic clk, rstn, pumpOn, secured, wrStb, rdStb, sec, lock;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [7:0] mem [0:514];
    logic [3:0] bp;
    int bad_count, compares, seed, cyc;
    eepc_ctrl dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .pumpOn(pumpOn),
        .secured(secured));
    eepc_cpu cpu_u (.clk(clk), .addr(addr), .wdata(wdata), .wrStb(wrStb),
        .rdStb(rdStb), .rdata(rdata));
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            test_done();
        end
    end
    // ------------------------------------------
    // reference model and helpers
    // ------------------------------------------
    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu_u.rd(a, d);
        chk(d, e);
        if (a == `EEPC_NVCFG_ADDR) bp = mem[512][3:0];
    endtask
    task automatic acr();
        logic [7:0] r;
        cpu_u.rd(`EEPC_ACR_ADDR, r);
        chk(r & 8'h1F, {3'h0, ~sec, bp});
    endtask
    function automatic bit ok(input int i, input int m);
        if (i >= 512) return i == 512 ? !sec : !lock;
        if (bp[i >> 7]) return 1'b0;
        return !(sec && (m >= 2 || (i >= 240 && i < 256)));
    endfunction
    task automatic boot();
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        sec = ~mem[512][4];
        bp = mem[512][3:0];
        lock = ~mem[513][7];
        repeat (6) @(posedge clk);
    endtask
    // program or erase one target the way software is told to
    task automatic op(input int i, input logic [7:0] d, input int m,
        input bit au);
        logic [7:0] c, r;
        int n;
        bit k;
        c = {3'h0, 2'(m), 1'b1, au, 1'b0};
        k = ok(i, m);
        cpu_u.wr(`EEPC_CTRL_ADDR, c);
        cpu_u.wr(16'h0800 + 16'(i), d);
        cpu_u.wr(`EEPC_CTRL_ADDR, c | 8'h01);
        @(posedge clk);
        #1;
        chk({7'h0, pumpOn}, {7'h0, k});
        n = 0;
        if (au) begin
            do begin
                cpu_u.rd(`EEPC_CTRL_ADDR, r);
                n++;
            end while (r[0] && n < 200);
        end else begin
            repeat (40) @(posedge clk);
            cpu_u.wr(`EEPC_CTRL_ADDR, 8'h00);
            cpu_u.rd(`EEPC_CTRL_ADDR, r);
        end
        chk(r & 8'h05, 8'h04);
        // bulk walks one cell per clock after the pump drops
        repeat (520) @(posedge clk);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h00);
        if (k && m == 0) mem[i] = mem[i] & d;
        else if (k && (m == 1 || i >= 512)) mem[i] = 8'hFF;
        else if (k) begin
            for (n = 0; n < 512; n++)
                if ((m == 3 || n / 128 == i / 128) && ok(n, m)) mem[n] = 8'hFF;
        end
        if (!mem[512][4]) sec = 1'b1;
    endtask
    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial begin
        int n, m, a, b;
        seed = 32'h381e;
        rstn = 1'b0;
        for (n = 0; n < 515; n++) mem[n] = 8'hFF;
        boot();
        rdc(`EEPC_CTRL_ADDR, 8'h00);
        acr();
        rdc(16'h0A05, 8'h00);
        a = $random(seed) & 511;
        rdc(16'h0800 + 16'(a), 8'hFF);
        cpu_u.wr(`EEPC_DIVH_ADDR, 8'h80);
        cpu_u.wr(`EEPC_DIVL_ADDR, 8'h02);
        rdc(`EEPC_DIVL_ADDR, 8'h02);
        op(a, 8'h00, 0, 0);
        rdc(16'h0800 + 16'(a), mem[a]);
        op(512, 8'hF0, 0, 1);
        rdc(`EEPC_NVCFG_ADDR, 8'hF0);
        acr();
        $display("test protect done");
        for (n = 0; n < 4; n++) begin
            op(256, ~(8'h01 << n), 0, n[0]);
            rdc(16'h0900, mem[256]);
        end
        for (m = 0; m < 4; m++) begin
            a = $random(seed) & 511;
            for (n = 0; n < 3; n++) begin
                b = a ^ (n == 2 ? 256 : n);
                op(b, 8'($random(seed)) | ~mem[b], 0, m[0]);
            end
            op(a, m == 0 ? ~mem[a] : 8'h00, m, m[1]);
            for (n = 0; n < 3; n++) begin
                b = a ^ (n == 2 ? 256 : n);
                rdc(16'h0800 + 16'(b), mem[b]);
            end
        end
        $display("test modes done");
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h01);
        rdc(`EEPC_CTRL_ADDR, 8'h00);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h04);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h05);
        rdc(`EEPC_CTRL_ADDR, 8'h04);
        cpu_u.wr(16'h0810, 8'h12);
        cpu_u.wr(16'h0820, 8'h34);
        rdc(16'h0830, 8'h34);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h05);
        repeat (40) @(posedge clk);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h00);
        cpu_u.wr(`EEPC_CTRL_ADDR, 8'h00);
        mem[48] = mem[48] & 8'h34;
        rdc(16'h0830, mem[48]);
        rdc(16'h0820, mem[32]);
        $display("test latch done");
        op(300, 8'h0F | ~mem[300], 0, 0);
        op(512, 8'hEF, 0, 0);
        chk({7'h0, secured}, 8'h01);
        acr();
        op(245, 8'h00, 0, 0);
        rdc(16'h08F5, mem[245]);
        op(512, 8'hFF, 1, 0);
        op(300, 8'h00, 2, 0);
        rdc(16'h092C, mem[300]);
        op(272, 8'h5A | ~mem[272], 0, 1);
        rdc(16'h0910, mem[272]);
        op(513, 8'h7F, 0, 0);
        boot();
        chk({7'h0, secured}, 8'h01);
        acr();
        rdc(`EEPC_DIVH_ADDR, 8'h7F);
        cpu_u.wr(`EEPC_DIVL_ADDR, 8'h02);
        rdc(`EEPC_DIVL_ADDR, mem[514]);
        op(513, 8'hFF, 1, 0);
        rdc(`EEPC_NVDIVH_ADDR, mem[513]);
        $display("test security done");
        test_done();
    end
endmodule
